// ==== logic/fault_monitor_pkg.sv ====
// Constants of the fault monitor: register map, field layout, reset values, timing.
// Assumes a 200 MHz master clock and a 32-bit Avalon-MM register port.
package fault_monitor_pkg;

    // Register byte offsets
    localparam logic [4:0] ENABLE_OFS = 5'h00;
    localparam logic [4:0] CONFIG_OFS = 5'h04;
    localparam logic [4:0] ERROR_OFS = 5'h08;
    localparam logic [4:0] COMMAND_OFS = 5'h0c;
    localparam logic [4:0] STATUS_SEL_OFS = 5'h10;
    localparam logic [4:0] STATE_OFS = 5'h14;

    // Flag and enable bit positions (same layout in both registers)
    localparam int FLAG_W = 9;
    localparam int DISCONNECT_BIT = 0;
    localparam int OVERTEMP_BIT = 1;
    localparam int SHORT_BIT = 2;
    localparam int FLASH_BIT = 3;
    localparam int WATCHDOG_BIT = 4;
    localparam int PERSIST_BIT = 5;
    localparam int OSC_BIT = 6;
    localparam int BITCLK_BIT = 7;
    localparam int FRAMECLK_BIT = 8;

    // Configuration fields
    localparam int WD_SEL_LSB = 0;
    localparam int PERSIST_SEL_LSB = 2;
    localparam int WD_RETURN_BIT = 4;
    localparam int PERSIST_RETURN_BIT = 5;
    localparam int CLASS_D_BIT = 6;
    localparam int CONFIG_W = 7;
    localparam logic [1:0] PERIOD_2S_SEL = 2'h2;
    localparam logic [6:0] CONFIG_RESET = 7'h0a;

    // Command bits
    localparam int SERVICE_CMD_BIT = 0;
    localparam int POWER_UP_CMD_BIT = 1;
    localparam int POWER_DOWN_CMD_BIT = 2;

    // Watchdog and persistence periods in milliseconds
    localparam logic [12:0] PERIOD_125MS = 13'd125;
    localparam logic [12:0] PERIOD_500MS = 13'd500;
    localparam logic [12:0] PERIOD_2S = 13'd2000;
    localparam logic [12:0] PERIOD_4S = 13'd4000;

    // Times and their cycle counts at the master clock rate
    localparam int CLOCK_MHZ = 200;
    localparam int MS_NS = 1000000;
    localparam int PWM_HIGH_NS = 62500;
    localparam int OSC_SWITCH_US = 500;
    localparam int SAI_STOP_US = 100;
    localparam int FRAME_FAST_PCT = 5;
    localparam int MS_CYCLES = MS_NS * CLOCK_MHZ / 1000;
    localparam int PWM_HIGH_CYCLES = (PWM_HIGH_NS * CLOCK_MHZ + 999) / 1000;
    localparam int OSC_SWITCH_CYCLES = OSC_SWITCH_US * CLOCK_MHZ;
    localparam int SAI_STOP_CYCLES = SAI_STOP_US * CLOCK_MHZ;
    localparam int FRAME_NOMINAL_CYCLES = 4167;

    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_RUN = 2'b01,
        WD_ONCE = 2'b11
    } wd_state_e;

endpackage : fault_monitor_pkg

// ==== logic/fault_monitor_unit.sv ====
// Fault monitor: sticky error flags, detectors, watchdog and persistence counters.
// Assumes all detector inputs are synchronous to clock; software on Avalon-MM.
//
// Summary of operation
// - Enabled speaker presence checked at analog power-up
// - Overtemp flagged while enabled and die hot
// - Short sensing only between analog power-up/down
// - Short sets flag, forces both outputs off
// - Class D pulse high too long trips short
// - Flash errors flag and stop that channel
// - Started watchdog ignores enable clear
// - First watchdog overflow sets its flag
// - Watchdog period selectable, 2s default
// - Watchdog flag clears only after service
// - Optional second overflow returns to wait
// - Persistence counter runs while errors exist
// - Persistence period selectable, optional return
// - Persistence return clears enables, keeps flags
// - Stopped resonator switches to RC clock
// - Switchover happens even with monitoring off
// - Error read stalls busy until switchover
// - Osc flag re-sets while resonator stays stopped
// - Enabled bit/frame clock stop sets flag
// - Fast frame clock resets assignment, stops play
// - Status pins selectable to report errors
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module fault_monitor_unit #(
    parameter int MS_CYCLES = fault_monitor_pkg::MS_CYCLES,
    parameter int PWM_HIGH_CYCLES = fault_monitor_pkg::PWM_HIGH_CYCLES,
    parameter int OSC_SWITCH_CYCLES = fault_monitor_pkg::OSC_SWITCH_CYCLES,
    parameter int SAI_STOP_CYCLES = fault_monitor_pkg::SAI_STOP_CYCLES,
    parameter int FRAME_NOMINAL_CYCLES = fault_monitor_pkg::FRAME_NOMINAL_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Avalon-MM register port
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Detector inputs
    input wire logic speaker_present,
    input wire logic die_overtemp,
    input wire logic short_sense,
    input wire logic pwm_out,
    input wire logic flash_read_error,
    input wire logic flash_range_error,
    input wire logic [1:0] flash_channel,
    input wire logic resonator_stopped,
    input wire logic bitclk,
    input wire logic frameclk,
    // Actions on the rest of the device
    output logic speaker_out_pos_off,
    output logic speaker_out_neg_off,
    output logic [3:0] channel_stop,
    output logic audio_assign_reset,
    output logic cmd_wait_return,
    output logic rc_clock_select,
    output logic command_busy_n,
    output logic status_out_a,
    output logic status_out_b
);
    localparam int FW = fault_monitor_pkg::FLAG_W;
    localparam int CW = fault_monitor_pkg::CONFIG_W;
    localparam int FRAME_FAST_CYCLES = FRAME_NOMINAL_CYCLES * 100 / (100 + fault_monitor_pkg::FRAME_FAST_PCT);

    generate
        if (MS_CYCLES < 2 || PWM_HIGH_CYCLES < 1 || OSC_SWITCH_CYCLES < 1 || SAI_STOP_CYCLES < 2
                || FRAME_FAST_CYCLES < 2 || FRAME_NOMINAL_CYCLES >= SAI_STOP_CYCLES) begin : g_bad
            $error("fault_monitor_unit: timing parameters out of range");
        end
    endgenerate

    function automatic logic [12:0] period_ms(input logic [1:0] sel);
        case (sel)
            2'h0: period_ms = fault_monitor_pkg::PERIOD_125MS;
            2'h1: period_ms = fault_monitor_pkg::PERIOD_500MS;
            2'h2: period_ms = fault_monitor_pkg::PERIOD_2S;
            default: period_ms = fault_monitor_pkg::PERIOD_4S;
        endcase
    endfunction : period_ms

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    // Registers
    logic [FW-1:0] enable_r, flags_r;
    logic [CW-1:0] config_r;
    logic [1:0] status_sel_r;
    logic ack_r, analog_up_r, short_off_r, serviced_r, persist_run_r;
    logic [31:0] readdata_r;
    fault_monitor_pkg::wd_state_e wd_state_r, wd_state_nxt;
    logic [31:0] ms_cnt_r, pwm_cnt_r, osc_cnt_r, bit_cnt_r, frame_cnt_r;
    logic [12:0] wd_ms_r, persist_ms_r;
    logic bitclk_prev_r, frameclk_prev_r, frame_seen_r;
    logic [3:0] channel_stop_r;
    logic audio_assign_reset_r, cmd_wait_return_r;

    // Bus decode
    wire logic request = read | write;
    wire logic err_read = read && address == fault_monitor_pkg::ERROR_OFS;
    wire logic osc_pending = resonator_stopped && !rc_clock_select;
    wire logic stall = err_read && osc_pending;
    wire logic wr_go = write && ack_r;
    wire logic [31:0] wmask = lane_mask(byteenable);
    wire logic wr_enable = wr_go && address == fault_monitor_pkg::ENABLE_OFS;
    wire logic wr_config = wr_go && address == fault_monitor_pkg::CONFIG_OFS;
    wire logic wr_clear = wr_go && address == fault_monitor_pkg::ERROR_OFS && byteenable[0];
    wire logic wr_cmd = wr_go && address == fault_monitor_pkg::COMMAND_OFS && byteenable[0];
    wire logic wr_sel = wr_go && address == fault_monitor_pkg::STATUS_SEL_OFS && byteenable[0];
    wire logic service_cmd = wr_cmd && writedata[fault_monitor_pkg::SERVICE_CMD_BIT];
    wire logic power_up_cmd = wr_cmd && writedata[fault_monitor_pkg::POWER_UP_CMD_BIT];
    wire logic power_down_cmd = wr_cmd && writedata[fault_monitor_pkg::POWER_DOWN_CMD_BIT];
    wire logic [31:0] state_word = {24'h0, wd_state_r, persist_run_r, serviced_r, short_off_r,
                                    analog_up_r, rc_clock_select, osc_pending};
    wire logic [31:0] rd_mux =
        address == fault_monitor_pkg::ENABLE_OFS ? {{(32-FW){1'b0}}, enable_r} :
        address == fault_monitor_pkg::CONFIG_OFS ? {{(32-CW){1'b0}}, config_r} :
        address == fault_monitor_pkg::ERROR_OFS ? {{(32-FW){1'b0}}, flags_r} :
        address == fault_monitor_pkg::STATUS_SEL_OFS ? {30'h0, status_sel_r} :
        address == fault_monitor_pkg::STATE_OFS ? state_word : 32'h0;

    assign waitrequest = request && !ack_r;
    assign readdata = readdata_r;
    assign command_busy_n = !stall;

    // Millisecond tick shared by both long counters
    wire logic ms_tick = ms_cnt_r == 32'(MS_CYCLES - 1);

    // Detectors
    wire logic disconnect_hit = power_up_cmd && !analog_up_r && !speaker_present;
    wire logic class_d = config_r[fault_monitor_pkg::CLASS_D_BIT];
    wire logic pwm_stuck = class_d && analog_up_r && pwm_cnt_r == 32'(PWM_HIGH_CYCLES);
    wire logic short_hit = enable_r[fault_monitor_pkg::SHORT_BIT] && analog_up_r
                           && (short_sense || pwm_stuck);
    wire logic flash_hit = enable_r[fault_monitor_pkg::FLASH_BIT] && (flash_read_error || flash_range_error);
    wire logic osc_switch = osc_cnt_r == 32'(OSC_SWITCH_CYCLES);
    wire logic bit_stopped = bit_cnt_r == 32'(SAI_STOP_CYCLES);
    wire logic frame_stopped = frame_cnt_r == 32'(SAI_STOP_CYCLES);
    wire logic frame_rise = frameclk && !frameclk_prev_r;
    wire logic frame_fast = frame_rise && frame_seen_r && frame_cnt_r < 32'(FRAME_FAST_CYCLES - 1);

    // Watchdog
    wire logic wd_period_end = ms_tick && wd_ms_r == period_ms(config_r[fault_monitor_pkg::WD_SEL_LSB +: 2]) - 13'd1;
    wire logic wd_overflow = wd_state_r != fault_monitor_pkg::WD_IDLE && wd_period_end && !service_cmd;
    wire logic wd_return = wd_overflow && wd_state_r == fault_monitor_pkg::WD_ONCE
                           && config_r[fault_monitor_pkg::WD_RETURN_BIT];

    // Persistence counter
    wire logic any_error = |flags_r;
    wire logic persist_overflow = persist_run_r && any_error && ms_tick
        && persist_ms_r == period_ms(config_r[fault_monitor_pkg::PERSIST_SEL_LSB +: 2]) - 13'd1;
    wire logic persist_return = persist_overflow && config_r[fault_monitor_pkg::PERSIST_RETURN_BIT];

    wire logic [FW-1:0] flag_set;
    assign flag_set[fault_monitor_pkg::DISCONNECT_BIT] =
        enable_r[fault_monitor_pkg::DISCONNECT_BIT] && disconnect_hit;
    assign flag_set[fault_monitor_pkg::OVERTEMP_BIT] =
        enable_r[fault_monitor_pkg::OVERTEMP_BIT] && die_overtemp;
    assign flag_set[fault_monitor_pkg::SHORT_BIT] = short_hit;
    assign flag_set[fault_monitor_pkg::FLASH_BIT] = flash_hit;
    assign flag_set[fault_monitor_pkg::WATCHDOG_BIT] = wd_overflow && wd_state_r == fault_monitor_pkg::WD_RUN;
    assign flag_set[fault_monitor_pkg::PERSIST_BIT] = persist_overflow;
    // Level set while stopped after switchover, so a clear cannot hide a dead resonator
    assign flag_set[fault_monitor_pkg::OSC_BIT] =
        enable_r[fault_monitor_pkg::OSC_BIT] && resonator_stopped && (rc_clock_select || osc_switch);
    assign flag_set[fault_monitor_pkg::BITCLK_BIT] = enable_r[fault_monitor_pkg::BITCLK_BIT] && bit_stopped;
    assign flag_set[fault_monitor_pkg::FRAMECLK_BIT] = enable_r[fault_monitor_pkg::FRAMECLK_BIT]
        && (frame_stopped || frame_fast);

    // Watchdog flag survives a clear unless serviced first
    wire logic [FW-1:0] clear_mask = wr_clear ? ~(FW'(!serviced_r) << fault_monitor_pkg::WATCHDOG_BIT) : '0;
    wire logic [FW-1:0] flags_nxt = (flags_r & ~clear_mask) | flag_set;

    wire logic [FW-1:0] enable_wr = FW'((32'(enable_r) & ~wmask) | (writedata & wmask));
    wire logic [FW-1:0] enable_nxt = persist_return ? '0 : wr_enable ? enable_wr : enable_r;
    wire logic [CW-1:0] config_nxt = wr_config ? CW'((32'(config_r) & ~wmask) | (writedata & wmask)) : config_r;

    always_comb begin
        wd_state_nxt = wd_state_r;
        case (wd_state_r)
            fault_monitor_pkg::WD_IDLE: begin
                if (enable_r[fault_monitor_pkg::WATCHDOG_BIT]) wd_state_nxt = fault_monitor_pkg::WD_RUN;
            end
            // Enable is not looked at once running
            fault_monitor_pkg::WD_RUN: begin
                if (wd_overflow) wd_state_nxt = fault_monitor_pkg::WD_ONCE;
            end
            fault_monitor_pkg::WD_ONCE: begin
                if (service_cmd) wd_state_nxt = fault_monitor_pkg::WD_RUN;
            end
            default: wd_state_nxt = fault_monitor_pkg::WD_IDLE;
        endcase
    end

    // Bus handshake and registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
            readdata_r <= 32'h0;
            enable_r <= '0;
            config_r <= fault_monitor_pkg::CONFIG_RESET;
            status_sel_r <= 2'h0;
            flags_r <= '0;
        end else begin
            ack_r <= request && !ack_r && !stall;
            if (read && !ack_r && !stall) readdata_r <= rd_mux;
            enable_r <= enable_nxt;
            config_r <= config_nxt;
            if (wr_sel) status_sel_r <= writedata[1:0];
            flags_r <= flags_nxt;
        end
    end

    // Analog state, short shutdown, playback actions
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            analog_up_r <= 1'b0;
            short_off_r <= 1'b0;
            pwm_cnt_r <= 32'h0;
            channel_stop_r <= 4'h0;
            audio_assign_reset_r <= 1'b0;
            cmd_wait_return_r <= 1'b0;
        end else begin
            analog_up_r <= power_up_cmd ? 1'b1 : power_down_cmd ? 1'b0 : analog_up_r;
            short_off_r <= short_hit ? 1'b1 : power_down_cmd ? 1'b0 : short_off_r;
            pwm_cnt_r <= (pwm_out && pwm_cnt_r != 32'(PWM_HIGH_CYCLES)) ? pwm_cnt_r + 32'h1 :
                         pwm_out ? pwm_cnt_r : 32'h0;
            channel_stop_r <= (flash_hit ? 4'h1 << flash_channel : 4'h0) | {4{frame_fast}};
            audio_assign_reset_r <= frame_fast;
            cmd_wait_return_r <= wd_return || persist_return;
        end
    end

    // Long counters
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ms_cnt_r <= 32'h0;
            wd_state_r <= fault_monitor_pkg::WD_IDLE;
            wd_ms_r <= 13'h0;
            serviced_r <= 1'b0;
            persist_run_r <= 1'b0;
            persist_ms_r <= 13'h0;
        end else begin
            ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
            wd_state_r <= wd_state_nxt;
            wd_ms_r <= (service_cmd || wd_state_r == fault_monitor_pkg::WD_IDLE || wd_period_end) ? 13'h0 :
                       ms_tick ? wd_ms_r + 13'h1 : wd_ms_r;
            serviced_r <= service_cmd ? 1'b1 : wr_clear ? 1'b0 : serviced_r;
            persist_run_r <= persist_run_r || enable_r[fault_monitor_pkg::PERSIST_BIT];
            persist_ms_r <= (!any_error || !persist_run_r || persist_overflow) ? 13'h0 :
                            ms_tick ? persist_ms_r + 13'h1 : persist_ms_r;
        end
    end

    // Clock supervision
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_cnt_r <= 32'h0;
            bit_cnt_r <= 32'h0;
            frame_cnt_r <= 32'h0;
            bitclk_prev_r <= 1'b0;
            frameclk_prev_r <= 1'b0;
            frame_seen_r <= 1'b0;
        end else begin
            // Switchover regardless of monitor enable; back when resonator runs
            osc_cnt_r <= !resonator_stopped ? 32'h0 : osc_switch ? osc_cnt_r : osc_cnt_r + 32'h1;
            bitclk_prev_r <= bitclk;
            frameclk_prev_r <= frameclk;
            bit_cnt_r <= (bitclk != bitclk_prev_r) ? 32'h0 : bit_stopped ? bit_cnt_r : bit_cnt_r + 32'h1;
            frame_cnt_r <= frame_rise ? 32'h0 : frame_stopped ? frame_cnt_r : frame_cnt_r + 32'h1;
            frame_seen_r <= frame_stopped ? 1'b0 : frame_rise ? 1'b1 : frame_seen_r;
        end
    end

    assign rc_clock_select = osc_cnt_r == 32'(OSC_SWITCH_CYCLES);
    assign speaker_out_pos_off = short_off_r;
    assign speaker_out_neg_off = short_off_r;
    assign channel_stop = channel_stop_r;
    assign audio_assign_reset = audio_assign_reset_r;
    assign cmd_wait_return = cmd_wait_return_r;
    assign status_out_a = status_sel_r[0] && any_error;
    assign status_out_b = status_sel_r[1] && any_error;

    // Checks
    sequence s_short_trip;
        short_hit ##1 (flags_r[fault_monitor_pkg::SHORT_BIT]
            && speaker_out_pos_off && speaker_out_neg_off);
    endsequence

    AST_SHORT_OFF: assert property (@(posedge clock) disable iff (!arst_n)
        short_hit |-> s_short_trip)
        else $error("short did not set flag and force outputs off");
    AST_SHORT_WINDOW: assert property (@(posedge clock) disable iff (!arst_n)
        !analog_up_r && !flags_r[fault_monitor_pkg::SHORT_BIT] |=> !flags_r[fault_monitor_pkg::SHORT_BIT])
        else $error("short sensed outside analog power-up");
    AST_OVERTEMP: assert property (@(posedge clock) disable iff (!arst_n)
        enable_r[fault_monitor_pkg::OVERTEMP_BIT] && die_overtemp |=> flags_r[fault_monitor_pkg::OVERTEMP_BIT])
        else $error("overtemp flag not set");
    AST_WD_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
        wr_clear && !serviced_r && flags_r[fault_monitor_pkg::WATCHDOG_BIT]
        |=> flags_r[fault_monitor_pkg::WATCHDOG_BIT])
        else $error("watchdog flag cleared without service");
    AST_WD_RUNS: assert property (@(posedge clock) disable iff (!arst_n)
        wd_state_r != fault_monitor_pkg::WD_IDLE |=> wd_state_r != fault_monitor_pkg::WD_IDLE)
        else $error("watchdog stopped after start");
    AST_PERSIST_RETURN: assert property (@(posedge clock) disable iff (!arst_n)
        persist_return |=> enable_r == '0 && cmd_wait_return && $stable(status_sel_r)
            && (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("persistence return did not clear enables and keep flags");
    AST_OSC_MASK: assert property (@(posedge clock) disable iff (!arst_n)
        !enable_r[fault_monitor_pkg::OSC_BIT] && !flags_r[fault_monitor_pkg::OSC_BIT]
        |=> !flags_r[fault_monitor_pkg::OSC_BIT])
        else $error("osc flag set while monitoring disabled");
    AST_BUSY_READ: assert property (@(posedge clock) disable iff (!arst_n)
        err_read && osc_pending |-> waitrequest && !command_busy_n)
        else $error("error read answered before switchover");
    AST_STICKY: assert property (@(posedge clock) disable iff (!arst_n)
        !wr_clear |=> (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("flag dropped without clear");
    AST_FRAME_FAST: assert property (@(posedge clock) disable iff (!arst_n)
        frame_fast |=> audio_assign_reset && channel_stop == 4'hf)
        else $error("fast frame clock not acted on");

endmodule : fault_monitor_unit

`default_nettype wire

// ==== dv/fault_env_model.sv ====
// Far-side model: serial audio bit and frame clocks seen by the monitor.
// Assumes one master clock; stop and fast controls come from the bench.
`timescale 1ns/1ps
`default_nettype none
module fault_env_model (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Controls
    input wire logic bit_stop,
    input wire logic frame_fast,
    // Audio clocks
    output logic bitclk,
    output logic frameclk
);
    logic [4:0] cnt_r;
    // Period 20 is the nominal frame the bench sets; 10 is far beyond the fast limit
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 5'h00;
            bitclk <= 1'b0;
            frameclk <= 1'b0;
        end else begin
            bitclk <= bit_stop ? bitclk : ~bitclk;
            cnt_r <= (cnt_r >= (frame_fast ? 5'h09 : 5'h13)) ? 5'h00 : cnt_r + 5'h01;
            frameclk <= cnt_r < (frame_fast ? 5'h05 : 5'h0a);
        end
    end
endmodule : fault_env_model
`default_nettype wire

// ==== dv/fault_monitor_unit_tb.sv ====
// Directed tests of the fault monitor through its Avalon-MM register port.
// Assumes shortened counts: 8-cycle ms tick, so 125ms is 1000 cycles.
`timescale 1ns/1ps
`default_nettype none
module fault_monitor_unit_tb;
    localparam logic [4:0] EN = fault_monitor_pkg::ENABLE_OFS;
    localparam logic [4:0] CF = fault_monitor_pkg::CONFIG_OFS;
    localparam logic [4:0] ER = fault_monitor_pkg::ERROR_OFS;
    localparam logic [4:0] CM = fault_monitor_pkg::COMMAND_OFS;
    logic clock, arst_n, read, write, waitrequest, bit_stop, frame_fast, bitclk, frameclk;
    logic [4:0] address;
    logic [31:0] writedata, readdata, q;
    logic speaker_present, die_overtemp, short_sense, pwm_out, flash_read_error, flash_range_error;
    logic [1:0] flash_channel;
    logic resonator_stopped, speaker_out_pos_off, speaker_out_neg_off, audio_assign_reset;
    logic cmd_wait_return, rc_clock_select, command_busy_n, status_out_a, status_out_b;
    logic [3:0] channel_stop;
    logic [3:0] stop_seen = 4'h0;
    logic assign_seen = 1'b0;
    logic wait_seen = 1'b0;
    logic [3:0] byteenable = 4'hf;
    int failures = 0;
    int samples_checked = 0;
    fault_monitor_unit #(.MS_CYCLES(8), .PWM_HIGH_CYCLES(10), .OSC_SWITCH_CYCLES(20),
        .SAI_STOP_CYCLES(64), .FRAME_NOMINAL_CYCLES(20)) dut (.clock, .arst_n, .address, .read,
        .write, .byteenable, .writedata, .readdata, .waitrequest, .speaker_present,
        .die_overtemp, .short_sense, .pwm_out, .flash_read_error, .flash_range_error,
        .flash_channel, .resonator_stopped, .bitclk, .frameclk, .speaker_out_pos_off,
        .speaker_out_neg_off, .channel_stop, .audio_assign_reset, .cmd_wait_return,
        .rc_clock_select, .command_busy_n, .status_out_a, .status_out_b);
    fault_env_model env (.clock, .arst_n, .bit_stop, .frame_fast, .bitclk, .frameclk);
    // Pulses last one cycle, so they are caught here rather than polled
    always @(posedge clock) begin
        if (channel_stop !== 4'h0)
            stop_seen <= channel_stop;
        if (audio_assign_reset === 1'b1)
            assign_seen <= 1'b1;
        if (cmd_wait_return === 1'b1)
            wait_seen <= 1'b1;
    end
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pin(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : pin
    // Waitrequest is sampled at the rising edge, with the values the slave saw there
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 200);
        if (n >= 200)
            chk(32'h1, 32'h0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(q & m, exp);
    endtask : rd
    task automatic test_done;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial begin
        #100000;
        chk(32'h1, 32'h0);
        test_done();
    end
    initial begin
        {read, write, address, writedata, bit_stop, frame_fast} = '0;
        {speaker_present, die_overtemp, short_sense, pwm_out} = 4'h8;
        {flash_read_error, flash_range_error, flash_channel, resonator_stopped} = '0;
        arst_n = 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        rd(CF, 32'hff, 32'h0a);
        xfer(1'b1, 5'h18, 32'hff);
        rd(5'h18, 32'hffffffff, 32'h0);
        $display("reset and map done");
        xfer(1'b1, EN, 32'h2);
        die_overtemp <= 1'b1;
        cyc(3);
        die_overtemp <= 1'b0;
        xfer(1'b1, fault_monitor_pkg::STATUS_SEL_OFS, 32'h1);
        @(negedge clock);
        pin(status_out_a, 1'b1);
        pin(status_out_b, 1'b0);
        rd(ER, 32'h1ff, 32'h2);
        byteenable <= 4'h0;
        xfer(1'b1, ER, 32'hff);
        byteenable <= 4'hf;
        rd(ER, 32'h1ff, 32'h2);
        xfer(1'b1, ER, 32'hff);
        rd(ER, 32'h1ff, 32'h0);
        xfer(1'b1, EN, 32'h0);
        die_overtemp <= 1'b1;
        cyc(3);
        rd(ER, 32'h2, 32'h0);
        die_overtemp <= 1'b0;
        $display("overtemp done");
        xfer(1'b1, EN, 32'h5);
        short_sense <= 1'b1;
        cyc(3);
        rd(ER, 32'h4, 32'h0);
        xfer(1'b1, CM, 32'h2);
        cyc(2);
        rd(ER, 32'h5, 32'h4);
        short_sense <= 1'b0;
        @(negedge clock);
        pin(speaker_out_pos_off, 1'b1);
        pin(speaker_out_neg_off, 1'b1);
        xfer(1'b1, CM, 32'h4);
        xfer(1'b1, ER, 32'hff);
        rd(ER, 32'h1ff, 32'h0);
        @(negedge clock);
        pin(speaker_out_pos_off, 1'b0);
        xfer(1'b1, CF, 32'h4a);
        xfer(1'b1, CM, 32'h2);
        pwm_out <= 1'b1;
        cyc(8);
        pwm_out <= 1'b0;
        rd(ER, 32'h4, 32'h0);
        pwm_out <= 1'b1;
        cyc(12);
        pwm_out <= 1'b0;
        rd(ER, 32'h4, 32'h4);
        xfer(1'b1, CM, 32'h4);
        xfer(1'b1, ER, 32'hff);
        speaker_present <= 1'b0;
        xfer(1'b1, CM, 32'h2);
        rd(ER, 32'h1, 32'h1);
        xfer(1'b1, CM, 32'h4);
        xfer(1'b1, ER, 32'hff);
        $display("speaker done");
        xfer(1'b1, EN, 32'h8);
        for (int i = 0; i < 2; i++) begin
            flash_channel <= i ? 2'h1 : 2'h2;
            {flash_range_error, flash_read_error} <= i ? 2'b10 : 2'b01;
            cyc(1);
            {flash_range_error, flash_read_error} <= 2'b00;
            rd(ER, 32'h8, 32'h8);
            chk({28'h0, stop_seen}, i ? 32'h2 : 32'h4);
            xfer(1'b1, ER, 32'hff);
        end
        xfer(1'b1, CM, 32'h4);
        xfer(1'b1, EN, 32'h80);
        bit_stop <= 1'b1;
        cyc(80);
        rd(ER, 32'h180, 32'h80);
        bit_stop <= 1'b0;
        frame_fast <= 1'b1;
        cyc(40);
        frame_fast <= 1'b0;
        rd(ER, 32'h100, 32'h0);
        pin(assign_seen, 1'b1);
        chk({28'h0, stop_seen}, 32'hf);
        xfer(1'b1, EN, 32'h100);
        frame_fast <= 1'b1;
        cyc(40);
        frame_fast <= 1'b0;
        rd(ER, 32'h100, 32'h100);
        $display("flash and audio clocks done");
        xfer(1'b1, CF, 32'h08);
        xfer(1'b1, EN, 32'h10);
        xfer(1'b1, EN, 32'h0);
        cyc(1030);
        rd(ER, 32'h10, 32'h10);
        xfer(1'b1, ER, 32'hff);
        rd(ER, 32'h10, 32'h10);
        xfer(1'b1, CM, 32'h1);
        xfer(1'b1, ER, 32'hff);
        rd(ER, 32'h10, 32'h0);
        $display("watchdog done");
        xfer(1'b1, CF, 32'h20);
        xfer(1'b1, EN, 32'h22);
        die_overtemp <= 1'b1;
        cyc(1100);
        die_overtemp <= 1'b0;
        rd(ER, 32'h22, 32'h22);
        rd(EN, 32'h1ff, 32'h0);
        pin(wait_seen, 1'b1);
        xfer(1'b1, CF, 32'h0a);
        $display("persistence done");
        xfer(1'b1, EN, 32'h40);
        resonator_stopped <= 1'b1;
        fork
            xfer(1'b0, ER, 32'h0);
            begin
                cyc(6);
                @(negedge clock);
                pin(command_busy_n, 1'b0);
            end
        join
        rd(ER, 32'h40, 32'h40);
        pin(rc_clock_select, 1'b1);
        xfer(1'b1, ER, 32'hff);
        rd(ER, 32'h40, 32'h40);
        arst_n <= 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        cyc(30);
        pin(rc_clock_select, 1'b1);
        rd(ER, 32'h40, 32'h0);
        $display("oscillator done");
        test_done();
    end
endmodule : fault_monitor_unit_tb
`default_nettype wire
